// >>> core/rtpb_core.sv
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
// Overview of operation
// - nonzero run limit enables the run timer
// - limit reached stops drive, flags, prompts
// - remaining reads limit idle, time left running
// - clear-run input zeroes accumulated run time
// - accumulated time discarded while not running
// - count at intermediate target flags, keeps counting
// - count at final target flags, stops counting
// - clear-count input zeroes count and both flags
// - count targets default 1000; zero disables
// - fast pin a counts when function 35
// - length equals pulses over pulses per unit
// - length at target raises length-reached flag
// - resolution select scales the length unit
// - clear-length input zeroes length and flag
// - fast pin b feeds length when function 38
// - braking on above threshold, off below
// - threshold 110.0 to 140.0 percent, default 128.5
// - duty 20 to 100 percent, sets on time
module rtpb_core #(
    parameter int TICK_CYCLES  = rtpb_pkg::TICK_CYCLES,
    parameter int TENTH_MIN_MS = rtpb_pkg::TENTH_MIN_MS
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire logic [7:0]                addr,
    input  wire logic [31:0]               wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output wire logic [31:0]               rdata,
    input  wire logic                      drive_running,
    input  wire logic [15:0]               bus_voltage,
    input  wire logic [rtpb_pkg::N_DI-1:0] digital_input_terminal,
    input  wire logic                      fast_pulse_pin_a,
    input  wire logic                      fast_pulse_pin_b,
    output wire logic                      stop_drive,
    output wire logic                      run_prompt,
    output wire logic                      do_time_reached,
    output wire logic                      do_count_final,
    output wire logic                      do_count_inter,
    output wire logic                      do_length_reached,
    output wire logic                      brake_active,
    output wire logic                      brake_switch
);
    localparam int NS = rtpb_pkg::N_DI + 2;
    localparam logic [16:0] TICK_LAST  = 17'(TICK_CYCLES - 1);
    localparam logic [12:0] TENTH_LAST = 13'(TENTH_MIN_MS - 1);

    typedef struct packed {
        logic [NS-1:0]             sync1;
        logic [NS-1:0]             sync2;
        logic [rtpb_pkg::N_DI-1:0] lvl_d;
        logic [1:0]                fast_d;
        logic [16:0]               tick_cnt;
        logic                      tick;
        logic [2:0]                ctrl;
        logic [15:0]               limit;
        logic [15:0]               final_t;
        logic [15:0]               inter_t;
        logic [15:0]               tlen;
        logic [15:0]               ppl;
        logic [15:0]               thr;
        logic [7:0]                duty;
        logic [7:0]                fastfn;
        logic [31:0]               rdata;
        logic                      run_d;
        logic [12:0]               ms_acc;
        logic [15:0]               accum;
        logic                      tflag;
        logic                      stop;
        logic                      prompt;
        logic [15:0]               cnt;
        logic                      f_inter;
        logic                      f_final;
        logic [31:0]               len_acc;
        logic [31:0]               len;
        logic                      f_len;
        logic                      brk;
    } rtpb_core_s;

    function automatic rtpb_core_s rst_val();
        rtpb_core_s r;
        r         = '0;
        r.limit   = rtpb_pkg::RST_LIMIT;
        r.final_t = rtpb_pkg::RST_COUNT;
        r.inter_t = rtpb_pkg::RST_COUNT;
        r.tlen    = rtpb_pkg::RST_TLEN;
        r.ppl     = rtpb_pkg::RST_PPL;
        r.thr     = rtpb_pkg::RST_THR;
        r.duty    = rtpb_pkg::RST_DUTY;
        return r;
    endfunction

    localparam rtpb_core_s RST_ST = rst_val();

    rtpb_core_s st_ff;
    rtpb_core_s nxt;

    logic [rtpb_pkg::N_DI-1:0] di_rise;
    logic [1:0]                fast_rise;
    logic                      cnt_pulse;
    logic                      len_pulse;
    logic                      clr_run;
    logic                      clr_cnt;
    logic                      clr_len;
    logic [13:0]               scale;
    logic [31:0]               len_sum;
    logic [15:0]               remain;
    logic [15:0]               status;

    rtpb_if #(.N(rtpb_pkg::N_DI)) link_if ();

    assign link_if.raw    = st_ff.sync2[rtpb_pkg::N_DI-1:0];
    assign link_if.tick   = st_ff.tick;
    assign link_if.brk_on = st_ff.brk;
    assign link_if.duty   = st_ff.duty;

    rtpb_filt #(.N(rtpb_pkg::N_DI)) u_filt (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .io      (link_if.filt)
    );

    rtpb_pwm u_pwm (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .io      (link_if.pwm_m)
    );

    assign di_rise   = link_if.lvl & ~st_ff.lvl_d;
    assign fast_rise = st_ff.sync2[NS-1:NS-2] & ~st_ff.fast_d;
    assign clr_run   = link_if.lvl[rtpb_pkg::DI_CLR_RUN];
    assign clr_cnt   = link_if.lvl[rtpb_pkg::DI_CLR_CNT];
    assign clr_len   = link_if.lvl[rtpb_pkg::DI_CLR_LEN];

    // only one source feeds each counter
    assign cnt_pulse = (st_ff.fastfn == rtpb_pkg::FN_FAST_CNT) ? fast_rise[0]
                                                              : di_rise[rtpb_pkg::DI_CNT];
    assign len_pulse = (st_ff.fastfn == rtpb_pkg::FN_FAST_LEN) ? fast_rise[1]
                                                              : di_rise[rtpb_pkg::DI_LEN];

    assign scale   = rtpb_pkg::LEN_SCALE[st_ff.ctrl[rtpb_pkg::CTRL_RES_HI:rtpb_pkg::CTRL_RES_LO]];
    assign len_sum = st_ff.len_acc + (len_pulse ? {18'h0, scale} : 32'h0);

    always_comb begin
        remain = st_ff.limit;
        if (drive_running) begin
            remain = (st_ff.accum >= st_ff.limit) ? 16'h0 : st_ff.limit - st_ff.accum;
        end
    end

    always_comb begin
        status                     = '0;
        status[rtpb_pkg::ST_TIME]  = st_ff.tflag;
        status[rtpb_pkg::ST_FINAL] = st_ff.f_final;
        status[rtpb_pkg::ST_INTER] = st_ff.f_inter;
        status[rtpb_pkg::ST_LEN]   = st_ff.f_len;
        status[rtpb_pkg::ST_BRAKE] = st_ff.brk;
    end

    always_comb begin
        nxt          = st_ff;
        nxt.sync1    = {fast_pulse_pin_b, fast_pulse_pin_a, digital_input_terminal};
        nxt.sync2    = st_ff.sync1;
        nxt.lvl_d    = link_if.lvl;
        nxt.fast_d   = st_ff.sync2[NS-1:NS-2];
        nxt.tick     = (st_ff.tick_cnt == TICK_LAST);
        nxt.tick_cnt = nxt.tick ? 17'h0 : st_ff.tick_cnt + 17'h1;

        // register writes with range clamps
        if (wr_stb) begin
            case (addr)
                rtpb_pkg::A_CTRL: begin
                    nxt.ctrl = wdata[2:0];
                end
                rtpb_pkg::A_LIMIT: begin
                    nxt.limit = (wdata[15:0] > rtpb_pkg::LIMIT_MAX) ? rtpb_pkg::LIMIT_MAX
                                                                     : wdata[15:0];
                end
                rtpb_pkg::A_FINAL: begin
                    nxt.final_t = wdata[15:0];
                end
                rtpb_pkg::A_INTER: begin
                    nxt.inter_t = wdata[15:0];
                end
                rtpb_pkg::A_TLEN: begin
                    nxt.tlen = wdata[15:0];
                end
                rtpb_pkg::A_PPL: begin
                    nxt.ppl = wdata[15:0];
                end
                rtpb_pkg::A_THR: begin
                    if (wdata[15:0] < rtpb_pkg::THR_MIN) begin
                        nxt.thr = rtpb_pkg::THR_MIN;
                    end else if (wdata[15:0] > rtpb_pkg::THR_MAX) begin
                        nxt.thr = rtpb_pkg::THR_MAX;
                    end else begin
                        nxt.thr = wdata[15:0];
                    end
                end
                rtpb_pkg::A_DUTY: begin
                    if (wdata[7:0] < rtpb_pkg::DUTY_MIN) begin
                        nxt.duty = rtpb_pkg::DUTY_MIN;
                    end else if (wdata[7:0] > rtpb_pkg::DUTY_MAX) begin
                        nxt.duty = rtpb_pkg::DUTY_MAX;
                    end else begin
                        nxt.duty = wdata[7:0];
                    end
                end
                rtpb_pkg::A_FASTFN: begin
                    nxt.fastfn = wdata[7:0];
                end
                default: begin
                end
            endcase
        end

        // read data stands one cycle, zero otherwise
        nxt.rdata = 32'h0;
        if (rd_stb) begin
            case (addr)
                rtpb_pkg::A_CTRL:   nxt.rdata = {29'h0, st_ff.ctrl};
                rtpb_pkg::A_LIMIT:  nxt.rdata = {16'h0, st_ff.limit};
                rtpb_pkg::A_FINAL:  nxt.rdata = {16'h0, st_ff.final_t};
                rtpb_pkg::A_INTER:  nxt.rdata = {16'h0, st_ff.inter_t};
                rtpb_pkg::A_TLEN:   nxt.rdata = {16'h0, st_ff.tlen};
                rtpb_pkg::A_PPL:    nxt.rdata = {16'h0, st_ff.ppl};
                rtpb_pkg::A_THR:    nxt.rdata = {16'h0, st_ff.thr};
                rtpb_pkg::A_DUTY:   nxt.rdata = {24'h0, st_ff.duty};
                rtpb_pkg::A_FASTFN: nxt.rdata = {24'h0, st_ff.fastfn};
                rtpb_pkg::A_STATUS: nxt.rdata = {16'h0, status};
                rtpb_pkg::A_REMAIN: nxt.rdata = {16'h0, remain};
                rtpb_pkg::A_PCOUNT: nxt.rdata = {16'h0, st_ff.cnt};
                rtpb_pkg::A_LENGTH: nxt.rdata = st_ff.len;
                default:            nxt.rdata = 32'h0;
            endcase
        end

        // run timer, in tenths of a minute
        nxt.run_d = drive_running;
        if (!drive_running || clr_run) begin
            nxt.ms_acc = 13'h0;
            nxt.accum  = 16'h0;
        end else if (st_ff.tick && !st_ff.tflag) begin
            if (st_ff.ms_acc == TENTH_LAST) begin
                nxt.ms_acc = 13'h0;
                nxt.accum  = st_ff.accum + 16'h1;
            end else begin
                nxt.ms_acc = st_ff.ms_acc + 13'h1;
            end
        end
        if (st_ff.limit != 16'h0 && drive_running && nxt.accum >= st_ff.limit) begin
            nxt.tflag = 1'b1;
        end else if (clr_run || (drive_running && !st_ff.run_d)) begin
            nxt.tflag = 1'b0;
        end
        nxt.stop   = nxt.tflag && drive_running;
        nxt.prompt = nxt.tflag && !st_ff.tflag;

        // pulse counter, zero final target disables
        if (clr_cnt) begin
            nxt.cnt = 16'h0;
        end else if (cnt_pulse && st_ff.final_t != 16'h0 && st_ff.cnt < st_ff.final_t) begin
            nxt.cnt = st_ff.cnt + 16'h1;
        end
        nxt.f_inter = !clr_cnt && st_ff.inter_t != 16'h0 && nxt.cnt >= st_ff.inter_t;
        nxt.f_final = !clr_cnt && st_ff.final_t != 16'h0 && nxt.cnt >= st_ff.final_t;

        // length: remainder divider, one unit drained per clock
        if (clr_len) begin
            nxt.len_acc = 32'h0;
            nxt.len     = 32'h0;
        end else if (st_ff.ppl != 16'h0 && len_sum >= {16'h0, st_ff.ppl}) begin
            nxt.len_acc = len_sum - {16'h0, st_ff.ppl};
            nxt.len     = st_ff.len + 32'h1;
        end else begin
            nxt.len_acc = len_sum;
        end
        nxt.f_len = !clr_len && st_ff.tlen != 16'h0 && nxt.len >= {16'h0, st_ff.tlen};

        // braking with hold at equality
        if (!st_ff.ctrl[rtpb_pkg::CTRL_BRK_EN]) begin
            nxt.brk = 1'b0;
        end else if (bus_voltage > st_ff.thr) begin
            nxt.brk = 1'b1;
        end else if (bus_voltage < st_ff.thr) begin
            nxt.brk = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt;
        end
    end

    assign rdata             = st_ff.rdata;
    assign stop_drive        = st_ff.stop;
    assign run_prompt        = st_ff.prompt;
    assign do_time_reached   = st_ff.tflag;
    assign do_count_final    = st_ff.f_final;
    assign do_count_inter    = st_ff.f_inter;
    assign do_length_reached = st_ff.f_len;
    assign brake_active      = st_ff.brk;
    assign brake_switch      = link_if.pwm;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    limit_zero_a: assert property (
        (st_ff.limit == 16'h0 && !st_ff.tflag) |=> !st_ff.tflag)
        else $error("time flag set with timer disabled");

    time_stop_a: assert property (
        $rose(st_ff.tflag) |-> st_ff.prompt && st_ff.stop ##1 !st_ff.prompt)
        else $error("time reached without stop and one-cycle prompt");

    remain_idle_a: assert property (
        (rd_stb && addr == rtpb_pkg::A_REMAIN && !drive_running)
            |=> rdata == {16'h0, $past(st_ff.limit)})
        else $error("remaining time not equal to limit when idle");

    run_clear_a: assert property (
        clr_run |=> st_ff.accum == 16'h0 && st_ff.ms_acc == 13'h0)
        else $error("clear did not zero run time");

    run_discard_a: assert property (
        !drive_running |=> st_ff.accum == 16'h0)
        else $error("run time kept while not running");

    count_step_a: assert property (
        (!clr_cnt && cnt_pulse && st_ff.cnt < st_ff.final_t)
            |=> st_ff.cnt == $past(st_ff.cnt) + 16'h1)
        else $error("pulse not counted");

    count_stop_a: assert property (
        (!clr_cnt && st_ff.cnt >= st_ff.final_t) |=> $stable(st_ff.cnt))
        else $error("count moved past final target");

    count_clear_a: assert property (
        clr_cnt |=> st_ff.cnt == 16'h0 && !st_ff.f_inter && !st_ff.f_final)
        else $error("count clear incomplete");

    len_reach_a: assert property (
        st_ff.f_len |-> $past(st_ff.tlen) != 16'h0
            && st_ff.len >= {16'h0, $past(st_ff.tlen)})
        else $error("length flag without reaching target");

    len_clear_a: assert property (
        clr_len |=> st_ff.len == 32'h0 && !st_ff.f_len)
        else $error("length clear incomplete");

    brake_on_a: assert property (
        (st_ff.ctrl[rtpb_pkg::CTRL_BRK_EN] && bus_voltage > st_ff.thr) |=> st_ff.brk)
        else $error("braking not started above threshold");

    brake_off_a: assert property (
        (bus_voltage < st_ff.thr) |=> !st_ff.brk)
        else $error("braking not stopped below threshold");
endmodule

// >>> core/rtpb_filt.sv
`timescale 1ns/1ns
module rtpb_filt #(
    parameter int N = rtpb_pkg::N_DI
) (
    input wire logic sys_clk,
    input wire logic rstn,
    rtpb_if.filt     io
);
    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0] lvl;
    } rtpb_filt_s;

    rtpb_filt_s st_ff;
    rtpb_filt_s nxt;

    // a bit follows the input only after two equal samples
    always_comb begin
        nxt = st_ff;
        if (io.tick) begin
            nxt.prev = io.raw;
            nxt.lvl  = (io.raw & st_ff.prev) | (st_ff.lvl & (io.raw | st_ff.prev));
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt;
        end
    end

    assign io.lvl = st_ff.lvl;

    two_sample_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        $changed(st_ff.lvl) |-> $past(io.tick)
            && ((st_ff.lvl ^ $past(st_ff.lvl)) & ($past(io.raw) ^ $past(st_ff.prev))) == '0
            && ((st_ff.lvl ^ $past(st_ff.lvl)) & (st_ff.lvl ^ $past(io.raw))) == '0)
        else $error("filtered level changed without two equal samples");
endmodule

// >>> core/rtpb_pwm.sv
`timescale 1ns/1ns
module rtpb_pwm #(
    parameter int PERIOD = rtpb_pkg::PWM_PERIOD
) (
    input wire logic sys_clk,
    input wire logic rstn,
    rtpb_if.pwm_m    io
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          out;
    } rtpb_pwm_s;

    rtpb_pwm_s   st_ff;
    rtpb_pwm_s   nxt;
    logic [19:0] pos;
    logic [19:0] high;

    assign pos  = 20'(st_ff.cnt) * 20'(rtpb_pkg::PCT_FULL);
    assign high = 20'(io.duty) * 20'(PERIOD);

    always_comb begin
        nxt     = st_ff;
        nxt.cnt = (st_ff.cnt == LAST) ? '0 : st_ff.cnt + CW'(1);
        nxt.out = io.brk_on && (pos < high);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt;
        end
    end

    assign io.pwm = st_ff.out;

    pwm_off_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !io.brk_on |=> !io.pwm)
        else $error("braking switch on while braking inactive");

    pwm_full_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (io.brk_on && io.duty == 8'(rtpb_pkg::PCT_FULL)) |=> io.pwm)
        else $error("full duty did not keep switch on");
endmodule

// >>> inc/rtpb_if.sv
`timescale 1ns/1ns
interface rtpb_if #(
    parameter int N = rtpb_pkg::N_DI
);
    logic [N-1:0] raw;
    logic         tick;
    logic [N-1:0] lvl;
    logic         brk_on;
    logic [7:0]   duty;
    logic         pwm;

    modport filt (input raw, input tick, output lvl);
    modport pwm_m (input brk_on, input duty, output pwm);
endinterface

// >>> inc/rtpb_pkg.sv
package rtpb_pkg;
    // timing
    localparam int CLK_MHZ      = 125;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYCLES  = CLK_MHZ * TICK_US;
    localparam int MS_PER_S     = 1000;
    localparam int TENTH_MIN_S  = 6;
    localparam int TENTH_MIN_MS = TENTH_MIN_S * MS_PER_S;
    localparam int PWM_PERIOD   = 1250;
    localparam int PCT_FULL     = 100;

    // register byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_LIMIT  = 8'h04;
    localparam logic [7:0] A_FINAL  = 8'h08;
    localparam logic [7:0] A_INTER  = 8'h0c;
    localparam logic [7:0] A_TLEN   = 8'h10;
    localparam logic [7:0] A_PPL    = 8'h14;
    localparam logic [7:0] A_THR    = 8'h18;
    localparam logic [7:0] A_DUTY   = 8'h1c;
    localparam logic [7:0] A_FASTFN = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [7:0] A_REMAIN = 8'h28;
    localparam logic [7:0] A_PCOUNT = 8'h2c;
    localparam logic [7:0] A_LENGTH = 8'h30;

    // control and status fields
    localparam int CTRL_BRK_EN = 0;
    localparam int CTRL_RES_LO = 1;
    localparam int CTRL_RES_HI = 2;
    localparam int ST_TIME     = 0;
    localparam int ST_FINAL    = 1;
    localparam int ST_INTER    = 2;
    localparam int ST_LEN      = 3;
    localparam int ST_BRAKE    = 4;

    // input terminal assignment
    localparam int N_DI       = 5;
    localparam int DI_CNT     = 0;
    localparam int DI_LEN     = 1;
    localparam int DI_CLR_RUN = 2;
    localparam int DI_CLR_CNT = 3;
    localparam int DI_CLR_LEN = 4;

    localparam logic [7:0] FN_FAST_CNT = 8'h23;
    localparam logic [7:0] FN_FAST_LEN = 8'h26;

    // reset values and ranges
    localparam logic [15:0] RST_LIMIT = 16'h0000;
    localparam logic [15:0] LIMIT_MAX = 16'hfde8;
    localparam logic [15:0] RST_COUNT = 16'h03e8;
    localparam logic [15:0] RST_TLEN  = 16'h03e8;
    localparam logic [15:0] RST_PPL   = 16'h03e8;
    localparam logic [15:0] RST_THR   = 16'h0505;
    localparam logic [15:0] THR_MIN   = 16'h044c;
    localparam logic [15:0] THR_MAX   = 16'h0578;
    localparam logic [7:0]  RST_DUTY  = 8'h64;
    localparam logic [7:0]  DUTY_MIN  = 8'h14;
    localparam logic [7:0]  DUTY_MAX  = 8'h64;

    // length increment per pulse, in tenth-pulse units, per resolution
    localparam logic [3:0][13:0] LEN_SCALE = {14'h2710, 14'h03e8, 14'h0064, 14'h000a};
endpackage

// >>> verification/rtpb_core_test.sv
`timescale 1ns/1ns
module rtpb_core_test;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        rd_q = 1'b0;
    logic [31:0] rdata;
    logic        drive_running = 1'b0;
    logic [15:0] bus_voltage = 16'h03e8;
    logic [2:0]  clr = 3'h0;
    logic [1:0]  sel = 2'h0;
    logic        start = 1'b0;
    logic [7:0]  n_p = 8'h00;
    logic [15:0] half = 16'h0004;
    logic        pulse;
    logic        busy;
    logic        stop_drive, run_prompt, do_time, do_fin, do_int, do_len, brk, brk_sw;
    logic [31:0] expq[$];
    logic [31:0] lfsr = 32'hcfdb;
    logic [31:0] duty;
    int          num_errors = 0;
    int          n_tests = 0;
    int          n_prompt = 0;
    int          hi;

    always #4 sys_clk = ~sys_clk;

    rtpb_pulse_src SRC (.sys_clk(sys_clk), .start(start), .n_pulses(n_p), .half(half),
                        .pulse(pulse), .busy(busy));

    rtpb_core #(.TICK_CYCLES(10), .TENTH_MIN_MS(3)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .drive_running(drive_running),
        .bus_voltage(bus_voltage),
        .digital_input_terminal({clr, pulse & (sel == 2'h1), pulse & (sel == 2'h0)}),
        .fast_pulse_pin_a(pulse & (sel == 2'h3)), .fast_pulse_pin_b(pulse & (sel == 2'h2)),
        .stop_drive(stop_drive), .run_prompt(run_prompt), .do_time_reached(do_time),
        .do_count_final(do_fin), .do_count_inter(do_int), .do_length_reached(do_len),
        .brake_active(brk), .brake_switch(brk_sw));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        // one idle edge so a following call never re-raises the strobe in this step
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd_stb <= 1'b1;
        expq.push_back(e);
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic pulses(input logic [1:0] s, input logic [7:0] n, input logic [15:0] h);
        sel <= s;
        n_p <= n;
        half <= h;
        start <= 1'b1;
        repeat (2) @(posedge sys_clk);
        start <= 1'b0;
        for (int i = 0; i < 4000 && busy; i++) @(posedge sys_clk);
        repeat (60) @(posedge sys_clk);
    endtask

    // read results land one cycle after the strobe
    always @(posedge sys_clk) begin
        rd_q <= rd_stb;
        if (run_prompt === 1'b1) n_prompt++;
        if (rd_q) chk(expq.pop_front(), rdata);
    end

    task automatic complete_run;
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        complete_run;
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(rtpb_pkg::A_LIMIT, 32'h0);
        rd(rtpb_pkg::A_FINAL, 32'd1000);
        rd(rtpb_pkg::A_INTER, 32'd1000);
        rd(rtpb_pkg::A_THR, 32'd1285);
        rd(rtpb_pkg::A_DUTY, 32'd100);
        rd(8'h34, 32'h0);
        wr(rtpb_pkg::A_INTER, 32'd2);
        wr(rtpb_pkg::A_FINAL, 32'd3);
        pulses(2'h0, 8'd2, 16'd40);
        rd(rtpb_pkg::A_PCOUNT, 32'd2);
        rd(rtpb_pkg::A_STATUS, 32'h4);
        wr(rtpb_pkg::A_FASTFN, 32'h23);
        pulses(2'h3, 8'd3, 16'd4);
        rd(rtpb_pkg::A_PCOUNT, 32'd3);
        rd(rtpb_pkg::A_STATUS, 32'h6);
        clr <= 3'h2;
        repeat (60) @(posedge sys_clk);
        rd(rtpb_pkg::A_PCOUNT, 32'h0);
        chk(32'h0, {30'h0, do_fin, do_int});
        clr <= 3'h0;
        wr(rtpb_pkg::A_CTRL, 32'h2);
        wr(rtpb_pkg::A_FASTFN, 32'h26);
        wr(rtpb_pkg::A_PPL, 32'd40);
        wr(rtpb_pkg::A_TLEN, 32'd20);
        pulses(2'h2, 8'd8, 16'd4);
        rd(rtpb_pkg::A_LENGTH, 32'd20);
        chk(32'h1, {31'h0, do_len});
        clr <= 3'h4;
        repeat (60) @(posedge sys_clk);
        rd(rtpb_pkg::A_LENGTH, 32'h0);
        chk(32'h0, {31'h0, do_len});
        clr <= 3'h0;
        drive_running <= 1'b1;
        repeat (100) @(posedge sys_clk);
        chk(32'h0, {31'h0, do_time});
        drive_running <= 1'b0;
        wr(rtpb_pkg::A_LIMIT, 32'd2);
        drive_running <= 1'b1;
        rd(rtpb_pkg::A_REMAIN, 32'd2);
        repeat (100) @(posedge sys_clk);
        chk(32'h3, {30'h0, do_time, stop_drive});
        chk(32'd1, n_prompt);
        rd(rtpb_pkg::A_REMAIN, 32'h0);
        drive_running <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(rtpb_pkg::A_REMAIN, 32'd2);
        // restart after a stop that had time accumulated: a new run starts from zero
        drive_running <= 1'b1;
        rd(rtpb_pkg::A_REMAIN, 32'd2);
        repeat (45) @(posedge sys_clk);
        // clear while running, after time has accumulated again
        clr <= 3'h1;
        repeat (40) @(posedge sys_clk);
        rd(rtpb_pkg::A_REMAIN, 32'd2);
        chk(32'h0, {31'h0, do_time});
        drive_running <= 1'b0;
        clr <= 3'h0;
        repeat (60) @(posedge sys_clk);
        wr(rtpb_pkg::A_THR, 32'd1000);
        rd(rtpb_pkg::A_THR, 32'd1100);
        wr(rtpb_pkg::A_THR, 32'd1285);
        wr(rtpb_pkg::A_DUTY, 32'd5);
        rd(rtpb_pkg::A_DUTY, 32'd20);
        lfsr = lfsr_next(lfsr);
        duty = 32'd20 + (lfsr % 32'd81);
        wr(rtpb_pkg::A_DUTY, duty);
        wr(rtpb_pkg::A_CTRL, 32'h1);
        bus_voltage <= 16'd1286;
        repeat (5) @(posedge sys_clk);
        chk(32'h1, {31'h0, brk});
        hi = 0;
        repeat (1250) begin
            @(posedge sys_clk);
            if (brk_sw === 1'b1) hi++;
        end
        chk((duty * 32'd1250 + 32'd99) / 32'd100, hi);
        bus_voltage <= 16'd1285;
        repeat (5) @(posedge sys_clk);
        rd(rtpb_pkg::A_STATUS, 32'h10);
        bus_voltage <= 16'd1284;
        repeat (5) @(posedge sys_clk);
        chk(32'h0, {30'h0, brk, brk_sw});
        repeat (5) @(posedge sys_clk);
        complete_run;
    end
endmodule

// >>> verification/rtpb_pulse_src.sv
`timescale 1ns/1ns
module rtpb_pulse_src (
    input  wire logic        sys_clk,
    input  wire logic        start,
    input  wire logic [7:0]  n_pulses,
    input  wire logic [15:0] half,
    output logic             pulse,
    output logic             busy
);
    logic [15:0] cnt;
    logic [8:0]  edges;
    initial begin
        pulse = 1'b0;
        busy = 1'b0;
    end
    // sensor rests low; each level held for half cycles
    always @(posedge sys_clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            edges <= {n_pulses, 1'b0};
            cnt <= half;
        end else if (busy) begin
            if (cnt > 16'h0001) begin
                cnt <= cnt - 16'h0001;
            end else if (edges == 9'h000) begin
                busy <= 1'b0;
            end else begin
                pulse <= ~pulse;
                edges <= edges - 9'h001;
                cnt <= half;
            end
        end
    end
endmodule
